// ===== design/sdc_core.sv
// digital control timing core: watchdog period, interrupt pulse sequencer,
// reset line filter with stuck detection, and spi inter-frame gap check
// assumes control inputs come from logic on clk; pins arrive unsynchronised
`timescale 1ns/1ps
`default_nettype none
// Contract
// - watchdog period is 8 ms shifted left by the 3-bit code, up to 1024 ms
// - each interrupt is a 1 ms low pulse on the open-drain interrupt line
// - interrupt pulse starts are at least 5 ms apart; later requests wait
// - reset line level is filtered; glitches shorter than the window are ignored
// - stuck high after 1 ms of driven low not followed; stuck low after 250 ms
module sdc_core
    import sdc_pkg::*;
#(
    parameter int WD_BASE_CYC = SDC_WD_BASE_CYC,
    parameter int INT_PULSE_CYC = SDC_INT_PULSE_CYC,
    parameter int INT_SPACE_CYC = SDC_INT_SPACE_CYC,
    parameter int STUCK_HI_CYC = SDC_STUCK_HI_CYC,
    parameter int STUCK_LO_CYC = SDC_STUCK_LO_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [SDC_WD_CODE_W-1:0] watchdog_period_code,
    input wire logic wd_service,
    output logic wd_timeout,
    input wire logic irq_event,
    output logic interrupt_request_n_o,
    output logic interrupt_request_n_oe,
    input wire logic reset_drive_req,
    input wire logic system_reset_line_n_i,
    output logic system_reset_line_n_o,
    output logic system_reset_line_n_oe,
    output logic reset_line_level,
    output logic reset_stuck_high,
    output logic reset_stuck_low,
    input wire logic spi_csn_n,
    output logic spi_gap_error
);
    import sdc_pkg::*;

    logic [SDC_WD_CNT_W-1:0] wd_cnt_q, wd_cnt_d;
    logic [SDC_WD_CNT_W-1:0] wd_period;
    logic wd_to_q, wd_to_d;
    sdc_int_state_t int_st_q, int_st_d;
    logic [SDC_MS_CNT_W-1:0] int_cnt_q, int_cnt_d;
    logic pend_q, pend_d;
    logic drv_q, drv_d;
    logic [SDC_MS_CNT_W-1:0] hi_cnt_q, hi_cnt_d;
    logic [SDC_MS_CNT_W-1:0] lo_cnt_q, lo_cnt_d;
    logic sthi_q, sthi_d;
    logic stlo_q, stlo_d;
    logic filt_level;
    logic csn_s1_q, csn_s2_q, csn_prev_q;
    logic [SDC_GAP_CNT_W-1:0] gap_cnt_q, gap_cnt_d;
    logic gap_err_q, gap_err_d;

    // reset line glitch filter
    sdc_pin_filter #(
        .FILT_CYC(SDC_RST_FILT_CYC)
    ) u_rst_filter (
        .clk(clk),
        .rst(rst),
        .pin_i(system_reset_line_n_i),
        .level_o(filt_level),
        .cnt_o()
    );

    // watchdog: period doubles per code step; service restarts the count
    assign wd_period = SDC_WD_CNT_W'(WD_BASE_CYC) << watchdog_period_code;
    always_comb begin
        wd_to_d = 1'b0;
        wd_cnt_d = wd_cnt_q + 1'b1;
        if (wd_service) begin
            wd_cnt_d = '0;
        end else if (wd_cnt_q >= wd_period - 1'b1) begin
            wd_cnt_d = '0;
            wd_to_d = 1'b1;
        end
    end

    // interrupt sequencer; one counter spans pulse and spacing from start
    always_comb begin
        int_st_d = int_st_q;
        int_cnt_d = int_cnt_q;
        pend_d = pend_q;
        case (int_st_q)
            SDC_INT_IDLE: begin
                if (pend_q) begin
                    int_st_d = SDC_INT_LOW;
                    int_cnt_d = '0;
                    pend_d = 1'b0;
                end
            end
            SDC_INT_LOW: begin
                int_cnt_d = int_cnt_q + 1'b1;
                if (int_cnt_q == SDC_MS_CNT_W'(INT_PULSE_CYC - 1)) begin
                    int_st_d = SDC_INT_GAP;
                end
            end
            SDC_INT_GAP: begin
                int_cnt_d = int_cnt_q + 1'b1;
                if (int_cnt_q == SDC_MS_CNT_W'(INT_SPACE_CYC - 1)) begin
                    int_st_d = SDC_INT_IDLE;
                    int_cnt_d = '0;
                end
            end
            default: begin
                int_st_d = SDC_INT_IDLE;
                int_cnt_d = '0;
            end
        endcase
        // a new event in the same cycle as the take-over is kept pending
        if (irq_event) begin
            pend_d = 1'b1;
        end
    end

    // reset line stuck detection; counts restart whenever the cause lapses
    always_comb begin
        drv_d = reset_drive_req;
        hi_cnt_d = '0;
        lo_cnt_d = '0;
        sthi_d = 1'b0;
        stlo_d = 1'b0;
        if (drv_q && filt_level) begin
            sthi_d = sthi_q;
            hi_cnt_d = hi_cnt_q;
            if (hi_cnt_q == SDC_MS_CNT_W'(STUCK_HI_CYC - 1)) begin
                sthi_d = 1'b1;
            end else begin
                hi_cnt_d = hi_cnt_q + 1'b1;
            end
        end
        // only low that nobody here drives counts toward stuck low
        if (!drv_q && !filt_level) begin
            stlo_d = stlo_q;
            lo_cnt_d = lo_cnt_q;
            if (lo_cnt_q == SDC_MS_CNT_W'(STUCK_LO_CYC - 1)) begin
                stlo_d = 1'b1;
            end else begin
                lo_cnt_d = lo_cnt_q + 1'b1;
            end
        end
    end

    // spi gap: count synchronised high time, judge at each frame start
    always_comb begin
        gap_err_d = 1'b0;
        gap_cnt_d = gap_cnt_q;
        if (csn_s2_q) begin
            if (gap_cnt_q != SDC_GAP_CNT_W'(SDC_SPI_GAP_CYC)) begin
                gap_cnt_d = gap_cnt_q + 1'b1;
            end
        end else begin
            gap_cnt_d = '0;
            // frame start with too short an idle; sync delays cancel out
            if (csn_prev_q && gap_cnt_q < SDC_GAP_CNT_W'(SDC_SPI_GAP_CYC)) begin
                gap_err_d = 1'b1;
            end
        end
    end

    // all state registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wd_cnt_q <= '0;
            wd_to_q <= 1'b0;
            int_st_q <= SDC_INT_IDLE;
            int_cnt_q <= '0;
            pend_q <= 1'b0;
            drv_q <= 1'b0;
            hi_cnt_q <= '0;
            lo_cnt_q <= '0;
            sthi_q <= 1'b0;
            stlo_q <= 1'b0;
            csn_s1_q <= SDC_LINE_RST_VAL;
            csn_s2_q <= SDC_LINE_RST_VAL;
            csn_prev_q <= SDC_LINE_RST_VAL;
            gap_cnt_q <= SDC_GAP_CNT_W'(SDC_SPI_GAP_CYC); // first frame is fine
            gap_err_q <= 1'b0;
        end else begin
            wd_cnt_q <= wd_cnt_d;
            wd_to_q <= wd_to_d;
            int_st_q <= int_st_d;
            int_cnt_q <= int_cnt_d;
            pend_q <= pend_d;
            drv_q <= drv_d;
            hi_cnt_q <= hi_cnt_d;
            lo_cnt_q <= lo_cnt_d;
            sthi_q <= sthi_d;
            stlo_q <= stlo_d;
            csn_s1_q <= spi_csn_n;
            csn_s2_q <= csn_s1_q;
            csn_prev_q <= csn_s2_q;
            gap_cnt_q <= gap_cnt_d;
            gap_err_q <= gap_err_d;
        end
    end

    // outputs: open-drain lines only ever pull low
    assign wd_timeout = wd_to_q;
    assign interrupt_request_n_o = 1'b0;
    assign interrupt_request_n_oe = (int_st_q == SDC_INT_LOW);
    assign system_reset_line_n_o = 1'b0;
    assign system_reset_line_n_oe = drv_q;
    assign reset_line_level = filt_level;
    assign reset_stuck_high = sthi_q;
    assign reset_stuck_low = stlo_q;
    assign spi_gap_error = gap_err_q;

    AST_WD_EXPIRE: assert property (@(posedge clk) disable iff (rst)
        wd_to_q |-> $past(wd_cnt_q) == wd_period - 1'b1 && wd_cnt_q == '0)
        else $error("watchdog expired off its selected period");

    AST_INT_PULSE_LEN: assert property (@(posedge clk) disable iff (rst)
        $fell(interrupt_request_n_oe) |-> $past(int_cnt_q) == SDC_MS_CNT_W'(INT_PULSE_CYC - 1))
        else $error("interrupt low pulse has the wrong length");

    AST_INT_SPACING: assert property (@(posedge clk) disable iff (rst)
        $rose(interrupt_request_n_oe) && $past(int_st_q) == SDC_INT_IDLE
        |-> $past(int_st_q, 2) != SDC_INT_GAP || $past(int_cnt_q, 2) ==
            SDC_MS_CNT_W'(INT_SPACE_CYC - 1))
        else $error("interrupt pulses closer than the minimum spacing");

    AST_INT_HELD: assert property (@(posedge clk) disable iff (rst)
        irq_event && int_st_q != SDC_INT_IDLE |=> pend_q)
        else $error("interrupt request lost while spacing ran");

    AST_STUCK_HIGH: assert property (@(posedge clk) disable iff (rst)
        $rose(sthi_q) |-> $past(hi_cnt_q) == SDC_MS_CNT_W'(STUCK_HI_CYC - 1) && $past(drv_q))
        else $error("stuck high flagged without the full timeout");

    AST_STUCK_LOW: assert property (@(posedge clk) disable iff (rst)
        $rose(stlo_q) |-> $past(lo_cnt_q) == SDC_MS_CNT_W'(STUCK_LO_CYC - 1) && !$past(filt_level))
        else $error("stuck low flagged without the full timeout");

    AST_SPI_GAP: assert property (@(posedge clk) disable iff (rst)
        gap_err_q |-> $past(gap_cnt_q) < SDC_GAP_CNT_W'(SDC_SPI_GAP_CYC) && !$past(csn_s2_q)
            && $past(csn_prev_q))
        else $error("gap error raised on a long enough idle");

endmodule
`default_nettype wire

// ===== design/sdc_pkg.sv
// constants, timing counts and state types of the digital control timing core
// assumes a single 200 MHz clock; all times are turned into cycle counts here
package sdc_pkg;

    // clock rate
    localparam int SDC_CLK_MHZ = 200;

    // times as printed, in their own units
    localparam int SDC_WD_BASE_MS = 8;
    localparam int SDC_INT_PULSE_MS = 1;
    localparam int SDC_INT_SPACE_MS = 5;
    localparam int SDC_RST_FILT_US = 5;
    localparam int SDC_STUCK_HI_MS = 1;
    localparam int SDC_STUCK_LO_MS = 250;
    localparam int SDC_SPI_GAP_US = 10;

    // cycle counts derived from the times
    localparam int SDC_WD_BASE_CYC = SDC_WD_BASE_MS * 1000 * SDC_CLK_MHZ;
    localparam int SDC_INT_PULSE_CYC = SDC_INT_PULSE_MS * 1000 * SDC_CLK_MHZ;
    localparam int SDC_INT_SPACE_CYC = SDC_INT_SPACE_MS * 1000 * SDC_CLK_MHZ;
    localparam int SDC_RST_FILT_CYC = SDC_RST_FILT_US * SDC_CLK_MHZ;
    localparam int SDC_STUCK_HI_CYC = SDC_STUCK_HI_MS * 1000 * SDC_CLK_MHZ;
    localparam int SDC_STUCK_LO_CYC = SDC_STUCK_LO_MS * 1000 * SDC_CLK_MHZ;
    localparam int SDC_SPI_GAP_CYC = SDC_SPI_GAP_US * SDC_CLK_MHZ;

    // widths
    localparam int SDC_WD_CODE_W = 3;
    localparam int SDC_WD_CNT_W = 28;
    localparam int SDC_MS_CNT_W = 26;
    localparam int SDC_FILT_CNT_W = 10;
    localparam int SDC_GAP_CNT_W = 12;

    // reset values
    localparam logic SDC_LINE_RST_VAL = 1'b1;

    // interrupt pulse sequencer
    typedef enum logic [1:0] {
        SDC_INT_IDLE,
        SDC_INT_LOW,
        SDC_INT_GAP
    } sdc_int_state_t;

endpackage

// ===== design/sdc_pin_filter.sv
// glitch filter for an asynchronous pin: two-flop synchroniser, then a
// level that only moves after the new value held for FILT_CYC cycles
// assumes the pin idles high, as an open-drain line with pull-up does
`timescale 1ns/1ps
`default_nettype none
module sdc_pin_filter
    import sdc_pkg::*;
#(
    parameter int FILT_CYC = SDC_RST_FILT_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic pin_i,
    output logic level_o,
    output logic [SDC_FILT_CNT_W-1:0] cnt_o
);
    logic sync1_q;
    logic sync2_q;
    logic level_q;
    logic level_d;
    logic [SDC_FILT_CNT_W-1:0] cnt_q;
    logic [SDC_FILT_CNT_W-1:0] cnt_d;

    // next level: a differing sample must persist, any agreement restarts
    always_comb begin
        level_d = level_q;
        cnt_d = '0;
        if (sync2_q != level_q) begin
            if (cnt_q == SDC_FILT_CNT_W'(FILT_CYC - 1)) begin
                level_d = sync2_q;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    // first flop feeds only the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_q <= SDC_LINE_RST_VAL;
            sync2_q <= SDC_LINE_RST_VAL;
            level_q <= SDC_LINE_RST_VAL;
            cnt_q <= '0;
        end else begin
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
            level_q <= level_d;
            cnt_q <= cnt_d;
        end
    end

    assign level_o = level_q;
    assign cnt_o = cnt_q;

    // the level only flips after a full window of the new value
    AST_FILT_WINDOW: assert property (@(posedge clk) disable iff (rst)
        (level_q != level_d) |-> (cnt_q == SDC_FILT_CNT_W'(FILT_CYC - 1)) && (sync2_q == level_d))
        else $error("filtered level moved before the window elapsed");

endmodule
`default_nettype wire

// ===== test/sdc_mcu_model.sv
// microcontroller side: pulled-up reset and interrupt wires, spi frames
// assumes the bench raises start only while busy is low
`timescale 1ns/1ps
`default_nettype none
module sdc_mcu_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic line_oe,
    input wire logic irq_oe,
    input wire logic hold_low,
    input wire logic clamp_high,
    input wire logic start,
    input wire logic short_gap,
    output logic reset_line_n,
    output logic irq_line_n,
    output logic csn_n,
    output logic busy
);
    int cnt_q;
    int gap_q;
    // pull-up unless someone pulls low; clamp stands for a pin shorted high
    assign reset_line_n = clamp_high | ~(line_oe | hold_low);
    assign irq_line_n = ~irq_oe;
    // 16-cycle frame, then an idle gap that is too short only on request
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 0;
            gap_q <= 0;
        end else if (start && cnt_q == 0) begin
            gap_q <= short_gap ? 100 : 2100;
            cnt_q <= (short_gap ? 100 : 2100) + 16;
        end else if (cnt_q != 0) begin
            cnt_q <= cnt_q - 1;
        end
    end
    assign csn_n = !(cnt_q > gap_q);
    assign busy = cnt_q != 0;
endmodule
`default_nettype wire

// ===== test/test_sdc_core.sv
// self-checking bench for the timing core, long counts shortened
// assumes sdc_mcu_model on every pin; samples taken at rising edges
`timescale 1ns/1ps
`default_nettype none
module test_sdc_core;
    import sdc_pkg::*;
    localparam int WD = 16;
    localparam int PULSE = 8;
    localparam int SPACE = 40;
    localparam int HI = 20;
    localparam int LO = 50;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [SDC_WD_CODE_W-1:0] code = 3'h0;
    logic svc = 1'b0, irq = 1'b0, drv = 1'b0, hold = 1'b0;
    logic clamp = 1'b0, start = 1'b0, short_gap = 1'b0;
    logic wd_to, irq_o, irq_oe, rl_o, rl_oe, level, st_hi, st_lo, gap_err;
    logic line_n, irq_n, csn_n, busy;
    int n_errors = 0;
    int tests_run = 0;
    int gap_seen = 0;

    // 200 MHz
    always #2.5 clk = ~clk;
    // gap flags are one-cycle pulses, so tally them here
    always @(posedge clk) if (gap_err === 1'b1) gap_seen <= gap_seen + 1;

    sdc_core #(.WD_BASE_CYC(WD), .INT_PULSE_CYC(PULSE), .INT_SPACE_CYC(SPACE),
        .STUCK_HI_CYC(HI), .STUCK_LO_CYC(LO)) sdc_core_i (
        .clk(clk), .rst(rst), .watchdog_period_code(code), .wd_service(svc),
        .wd_timeout(wd_to), .irq_event(irq), .interrupt_request_n_o(irq_o),
        .interrupt_request_n_oe(irq_oe), .reset_drive_req(drv),
        .system_reset_line_n_i(line_n), .system_reset_line_n_o(rl_o),
        .system_reset_line_n_oe(rl_oe), .reset_line_level(level),
        .reset_stuck_high(st_hi), .reset_stuck_low(st_lo), .spi_csn_n(csn_n),
        .spi_gap_error(gap_err));

    sdc_mcu_model sdc_mcu_model_i (.clk(clk), .rst(rst), .line_oe(rl_oe),
        .irq_oe(irq_oe), .hold_low(hold), .clamp_high(clamp), .start(start),
        .short_gap(short_gap), .reset_line_n(line_n), .irq_line_n(irq_n),
        .csn_n(csn_n), .busy(busy));

    task automatic chk_bit(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic chk_int(input string what, input int exp, input int got);
        tests_run++;
        if (got != exp) begin
            n_errors++;
            $display("[ERR] %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic conclude;
        $display("mismatches %0d of %0d checks", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // a wait that ran out of its bound ends the run
    task automatic bound(input int n, input int lim);
        if (n >= lim) begin
            n_errors++;
            conclude();
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // every period code, serviced then left to expire
    task automatic t_wd;
        int n;
        for (int c = 0; c < 8; c++) begin
            code <= c[2:0];
            svc <= 1'b1;
            tick(1);
            svc <= 1'b0;
            n = 0;
            while (wd_to !== 1'b1 && n < 5000) begin
                tick(1);
                n++;
            end
            bound(n, 5000);
            chk_int("watchdog period", WD << c, n - 1);
        end
    endtask
    // second request lands while the first pulse is still low; watching starts
    // with the first request so the whole first pulse is seen
    task automatic t_irq;
        int fall1, fall2, width;
        fall1 = -1;
        fall2 = -1;
        width = 0;
        for (int t = 0; t < 200; t++) begin
            irq <= logic'(t == 0 || t == 4);
            tick(1);
            if (irq_n === 1'b0) width++;
            if (irq_n === 1'b0 && fall1 < 0) fall1 = t;
            else if (irq_n === 1'b0 && fall2 < 0 && t > fall1 + PULSE) fall2 = t;
        end
        chk_int("irq low cycles", 2 * PULSE, width);
        chk_bit("irq data", 1'b0, irq_o);
        chk_bit("irq spacing", 1'b1, fall2 - fall1 >= SPACE);
        chk_bit("irq held not lost", 1'b1, fall2 - fall1 <= SPACE + 2);
    endtask
    // device drives low but the pin stays high
    task automatic t_hi;
        clamp <= 1'b1;
        drv <= 1'b1;
        tick(3);
        chk_bit("reset drive oe", 1'b1, rl_oe);
        chk_bit("reset data", 1'b0, rl_o);
        tick(HI - 8);
        chk_bit("stuck high early", 1'b0, st_hi);
        tick(10);
        chk_bit("stuck high", 1'b1, st_hi);
        drv <= 1'b0;
        tick(4);
        chk_bit("stuck high clears", 1'b0, st_hi);
        clamp <= 1'b0;
    endtask
    // short glitch, then a held low that also runs into stuck low
    task automatic t_filt;
        int n;
        hold <= 1'b1;
        tick(500);
        hold <= 1'b0;
        tick(20);
        chk_bit("glitch ignored", 1'b1, level);
        tick(1100);
        hold <= 1'b1;
        n = 0;
        while (level !== 1'b0 && n < 1100) begin
            tick(1);
            n++;
        end
        bound(n, 1100);
        chk_bit("filter window", 1'b1, n >= 1000);
        tick(LO - 5);
        chk_bit("stuck low early", 1'b0, st_lo);
        tick(10);
        chk_bit("stuck low", 1'b1, st_lo);
        hold <= 1'b0;
        tick(1100);
        chk_bit("level back high", 1'b1, level);
        chk_bit("stuck low clears", 1'b0, st_lo);
    endtask
    // second gap is short, so only the third frame start is flagged
    task automatic t_spi;
        int n, base;
        base = gap_seen;
        for (int f = 0; f < 4; f++) begin
            short_gap <= logic'(f == 1);
            start <= 1'b1;
            tick(2);
            start <= 1'b0;
            n = 0;
            while (busy !== 1'b0 && n < 3000) begin
                tick(1);
                n++;
            end
            bound(n, 3000);
        end
        tick(10);
        chk_int("gap errors", 1, gap_seen - base);
    endtask

    initial begin
        tick(20);
        rst <= 1'b0;
        tick(2);
        t_wd();
        t_irq();
        t_hi();
        t_filt();
        t_spi();
        conclude();
    end
endmodule
`default_nettype wire
